// ---- amsr_readout.sv ----
`timescale 1ns/100ps
`include "amsr_cfg.svh"
module amsr_readout (
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  // Link pins from the host
  input  wire logic                   i_sclk,
  input  wire logic                   i_cs_n,
  // Mode settings, same clock domain
  input  wire logic [2:0]             i_output_protocol_select,
  input  wire logic                   i_clock_polarity_bit,
  input  wire logic                   i_clock_phase_bit,
  input  wire logic [1:0]             i_lane_width,
  input  wire logic                   i_fixed_pattern_en,
  input  wire logic [15:0]            i_fixed_pattern,
  // Conversion results in
  input  wire logic                   i_sample_valid,
  output logic                        o_sample_ready,
  input  wire amsr_pkg::amsr_pair_type i_sample,
  // Serial data lanes, bit 0 is lane zero
  output amsr_pkg::amsr_lanes_type    o_chan_a,
  output amsr_pkg::amsr_lanes_type    o_chan_b,
  // Status
  output logic                        o_busy,
  output logic                        o_underrun,
  output logic                        o_mode_error
);
  import amsr_pkg::*;

  typedef struct packed {
    logic [1:0]     sclk_sync;
    logic [1:0]     cs_sync;
    logic           sclk_prev;
    logic           cs_prev;
    amsr_phase_type phase;
    amsr_mode_type  mode;
    logic           armed;
    logic [3:0]     step;
    amsr_pair_type  word;
    amsr_lanes_type chan_a;
    amsr_lanes_type chan_b;
    logic           sample_ready;
    logic           busy;
    logic           underrun;
    logic           mode_error;
  } amsr_state_type;

  amsr_state_type s_r;
  amsr_state_type s_nxt;

  // FIFO side
  logic           fifo_out_valid;
  logic           fifo_out_ready;
  logic           fifo_in_ready;
  amsr_pair_type  fifo_out_data;

  // Edge detection on the synchronised pins
  logic           sclk_rise;
  logic           sclk_fall;
  logic           cs_fall;
  logic           cs_rise;
  logic           lead_edge;
  logic           trail_edge;
  logic           launch_edge;
  logic           is_ddr;
  logic           frame_start;

  // Lane mapping
  logic [5:0]     shift_amt;
  logic [15:0]    shifted_a;
  logic [15:0]    shifted_b;
  logic [3:0]     lane_bit_a;
  logic [3:0]     lane_bit_b;
  logic [3:0]     lane_en;
  logic [3:0]     lane_en_in;
  logic [3:0]     last_step;
  amsr_mode_type  mode_in;
  amsr_pair_type  word_in;
  logic           mode_bad;

  amsr_fifo #(
    .WIDTH ($bits(amsr_pair_type)),
    .DEPTH (`AMSR_FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (i_sample_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_sample),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  // Pins pass two flops before anything looks at them
  assign sclk_rise  = s_r.sclk_sync[1] && !s_r.sclk_prev;
  assign sclk_fall  = !s_r.sclk_sync[1] && s_r.sclk_prev;
  assign cs_fall    = !s_r.cs_sync[1] && s_r.cs_prev;
  assign cs_rise    = s_r.cs_sync[1] && !s_r.cs_prev;

  // Leading edge leaves the idle level set by polarity
  assign lead_edge  = s_r.mode.clock_polarity_bit ? sclk_fall : sclk_rise;
  assign trail_edge = s_r.mode.clock_polarity_bit ? sclk_rise : sclk_fall;
  assign is_ddr     = (s_r.mode.output_protocol_select == `AMSR_PROTO_DDR);

  always_comb begin
    if (is_ddr) begin
      launch_edge = sclk_rise || sclk_fall;
    end else if (s_r.mode.clock_phase_bit) begin
      launch_edge = lead_edge;
    end else begin
      launch_edge = trail_edge;
    end
  end

  // A new frame only opens from idle; settings are sampled here
  assign frame_start = cs_fall && (s_r.phase == AMSR_IDLE);
  assign fifo_out_ready = frame_start;

  // Unsupported codes and widths fall back to their own reset values
  always_comb begin
    mode_bad = 1'b0;
    mode_in.output_protocol_select = i_output_protocol_select;
    mode_in.clock_polarity_bit     = i_clock_polarity_bit;
    mode_in.clock_phase_bit        = i_clock_phase_bit;
    mode_in.lane_width             = i_lane_width;
    if (i_output_protocol_select != `AMSR_PROTO_SDR &&
        i_output_protocol_select != `AMSR_PROTO_DDR) begin
      mode_in.output_protocol_select = `AMSR_RST_PROTOCOL;
      mode_bad = 1'b1;
    end
    // DDR needs phase 1; phase 0 is forced up and flagged
    if (i_output_protocol_select == `AMSR_PROTO_DDR && !i_clock_phase_bit) begin
      mode_in.clock_phase_bit = 1'b1;
      mode_bad = 1'b1;
    end
    if (i_lane_width > `AMSR_WIDTH_FOUR) begin
      mode_in.lane_width = `AMSR_RST_WIDTH;
      mode_bad = 1'b1;
    end
  end

  // Fixed pattern replaces both results when enabled
  always_comb begin
    if (i_fixed_pattern_en) begin
      word_in.chan_a = i_fixed_pattern;
      word_in.chan_b = i_fixed_pattern;
    end else if (fifo_out_valid) begin
      word_in = fifo_out_data;
    end else begin
      word_in = s_r.word;
    end
  end

  // Steps per word: sixteen, eight or four for one, two, four lanes
  assign shift_amt = 6'({2'b00, s_r.step} << s_r.mode.lane_width);
  assign shifted_a = s_r.word.chan_a << shift_amt;
  assign shifted_b = s_r.word.chan_b << shift_amt;
  assign last_step = 4'((`AMSR_WORD_BITS >> s_r.mode.lane_width) - 1);

  genvar k;
  generate
    for (k = 0; k < `AMSR_LANES; k++) begin : g_lane
      // Lane k carries bit 15-k of each group, MSB group first
      assign lane_bit_a[k] = shifted_a[`AMSR_WORD_BITS-1-k];
      assign lane_bit_b[k] = shifted_b[`AMSR_WORD_BITS-1-k];
      assign lane_en[k]    = (k < (1 << s_r.mode.lane_width));
      assign lane_en_in[k] = (k < (1 << mode_in.lane_width));
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;
    s_nxt.sclk_sync = {s_r.sclk_sync[0], i_sclk};
    s_nxt.cs_sync   = {s_r.cs_sync[0], i_cs_n};
    s_nxt.sclk_prev = s_r.sclk_sync[1];
    s_nxt.cs_prev   = s_r.cs_sync[1];
    s_nxt.sample_ready = fifo_in_ready;

    case (s_r.phase)
      AMSR_IDLE: begin
        if (frame_start) begin
          s_nxt.phase      = AMSR_SHIFT;
          s_nxt.mode       = mode_in;
          s_nxt.mode_error = mode_bad;
          s_nxt.word       = word_in;
          s_nxt.underrun   = !fifo_out_valid && !i_fixed_pattern_en;
          s_nxt.step       = `AMSR_RST_STEP;
          // Phase 1 launches the MSB on the first leading edge
          s_nxt.armed      = mode_in.clock_phase_bit;
          s_nxt.busy       = 1'b1;
        end
      end
      AMSR_SHIFT: begin
        // A fourteen-bit read just stops early; chip select may rise mid-word
        if (cs_rise) begin
          s_nxt.phase = AMSR_IDLE;
          s_nxt.busy  = 1'b0;
        end else if (launch_edge) begin
          if (s_r.armed) begin
            s_nxt.armed = 1'b0;
          end else if (s_r.step == last_step) begin
            // Word exhausted; lanes hold the last bit until chip select rises
            s_nxt.phase = AMSR_DONE;
          end else begin
            s_nxt.step = s_r.step + 4'h1;
          end
        end
      end
      AMSR_DONE: begin
        if (cs_rise) begin
          s_nxt.phase = AMSR_IDLE;
          s_nxt.busy  = 1'b0;
        end
      end
      default: begin
        s_nxt.phase = AMSR_IDLE;
        s_nxt.busy  = 1'b0;
      end
    endcase

    // Drive lanes only inside a frame and only where enabled
    if (s_nxt.phase == AMSR_IDLE) begin
      s_nxt.chan_a.lane_oe = 4'h0;
      s_nxt.chan_b.lane_oe = 4'h0;
    end else if (s_r.phase == AMSR_IDLE) begin
      // First cycle of a frame must use the width just sampled, not the old one
      s_nxt.chan_a.lane_oe = lane_en_in;
      s_nxt.chan_b.lane_oe = lane_en_in;
    end else begin
      s_nxt.chan_a.lane_oe = lane_en;
      s_nxt.chan_b.lane_oe = lane_en;
    end
    // Output flops lag the step by one cycle; fine against a 200 ns link clock
    // Masked by the enables so an idle or unused lane never shows stale data
    s_nxt.chan_a.lane_out = lane_bit_a & s_nxt.chan_a.lane_oe;
    s_nxt.chan_b.lane_out = lane_bit_b & s_nxt.chan_b.lane_oe;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s_r.sclk_sync    <= 2'h0;
      s_r.cs_sync      <= 2'h3;
      s_r.sclk_prev    <= 1'b0;
      s_r.cs_prev      <= 1'b1;
      s_r.phase        <= AMSR_IDLE;
      s_r.mode.output_protocol_select <= `AMSR_RST_PROTOCOL;
      s_r.mode.clock_polarity_bit     <= `AMSR_RST_CPOL;
      s_r.mode.clock_phase_bit        <= `AMSR_RST_CPHA;
      s_r.mode.lane_width             <= `AMSR_RST_WIDTH;
      s_r.armed        <= 1'b0;
      s_r.step         <= `AMSR_RST_STEP;
      s_r.word.chan_a  <= `AMSR_RST_WORD;
      s_r.word.chan_b  <= `AMSR_RST_WORD;
      s_r.chan_a       <= '0;
      s_r.chan_b       <= '0;
      s_r.sample_ready <= 1'b0;
      s_r.busy         <= 1'b0;
      s_r.underrun     <= 1'b0;
      s_r.mode_error   <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_chan_a       = s_r.chan_a;
  assign o_chan_b       = s_r.chan_b;
  assign o_sample_ready = s_r.sample_ready;
  assign o_busy         = s_r.busy;
  assign o_underrun     = s_r.underrun;
  assign o_mode_error   = s_r.mode_error;
endmodule // amsr_readout

// ---- amsr_cfg.svh ----
`ifndef AMSR_CFG_SVH
`define AMSR_CFG_SVH
`define AMSR_WORD_BITS     16
`define AMSR_LANES         4
`define AMSR_FIFO_DEPTH    8
`define AMSR_PROTO_SDR     3'h0
`define AMSR_PROTO_DDR     3'h1
`define AMSR_WIDTH_ONE     2'h0
`define AMSR_WIDTH_TWO     2'h1
`define AMSR_WIDTH_FOUR    2'h2
`define AMSR_RST_PROTOCOL  3'h0
`define AMSR_RST_CPOL      1'b0
`define AMSR_RST_CPHA      1'b0
`define AMSR_RST_WIDTH     2'h0
`define AMSR_RST_STEP      4'h0
`define AMSR_RST_WORD      16'h0000
`endif

// ---- amsr_pkg.sv ----
package amsr_pkg;
  typedef struct packed {
    logic [15:0] chan_a;
    logic [15:0] chan_b;
  } amsr_pair_type;

  typedef struct packed {
    logic [2:0] output_protocol_select;
    logic       clock_polarity_bit;
    logic       clock_phase_bit;
    logic [1:0] lane_width;
  } amsr_mode_type;

  typedef struct packed {
    logic [3:0] lane_out;
    logic [3:0] lane_oe;
  } amsr_lanes_type;

  typedef enum logic [1:0] {
    AMSR_IDLE,
    AMSR_SHIFT,
    AMSR_DONE
  } amsr_phase_type;
endpackage

// ---- amsr_fifo.sv ----
`timescale 1ns/100ps
module amsr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr_ptr;
    logic [AW:0]                 rd_ptr;
  } amsr_fifo_state_type;

  amsr_fifo_state_type s_r;
  amsr_fifo_state_type s_nxt;
  logic                full;
  logic                empty;

  assign empty       = (s_r.wr_ptr == s_r.rd_ptr);
  assign full        = (s_r.wr_ptr[AW-1:0] == s_r.rd_ptr[AW-1:0]) && !empty;
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = s_r.mem[s_r.rd_ptr[AW-1:0]];

  always_comb begin
    s_nxt = s_r;
    if (i_in_valid && !full) begin
      s_nxt.mem[s_r.wr_ptr[AW-1:0]] = i_in_data;
      s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
    end
    if (i_out_ready && !empty) begin
      s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // amsr_fifo

// ---- amsr_readout_assertions.sv ----
`timescale 1ns/100ps
module amsr_readout_assertions (
  input wire logic                     i_clk,
  input wire logic                     i_reset_n,
  input wire logic                     i_sclk,
  input wire logic                     i_cs_n,
  input wire logic [2:0]               i_output_protocol_select,
  input wire logic [1:0]               i_lane_width,
  input wire logic                     i_sample_valid,
  input wire logic                     o_sample_ready,
  input wire amsr_pkg::amsr_lanes_type o_chan_a,
  input wire amsr_pkg::amsr_lanes_type o_chan_b,
  input wire logic                     o_busy,
  input wire logic                     o_mode_error
);
  import amsr_pkg::*;
  logic [3:0] mask;
  logic [3:0] oe;
  assign mask = i_lane_width == 2'h2 ? 4'hf : i_lane_width == 2'h1 ? 4'h3 : 4'h1;
  assign oe = o_chan_a.lane_oe | o_chan_b.lane_oe;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  idle_lanes_a: assert property (i_cs_n [*8] |-> oe == 4'h0)
    else $error("lanes on when idle");
  unused_lanes_a: assert property ((oe & ~mask) == 4'h0)
    else $error("unused lane on");
  masked_out_a: assert property ((o_chan_a.lane_out & ~o_chan_a.lane_oe) == 4'h0)
    else $error("masked lane not low");
  frame_start_a: assert property ($fell(i_cs_n) |-> ##[2:6] o_busy && oe[0])
    else $error("frame start missed");
  frame_end_a: assert property ($rose(i_cs_n) |-> ##[1:6] !o_busy ##1 oe == 4'h0)
    else $error("frame end missed");
  lanes_hold_a: assert property ((!i_cs_n && $stable(i_sclk)) [*8] |=> $stable(o_chan_b))
    else $error("lane moved without edge");
  ready_reset_a: assert property ($rose(i_reset_n) |-> !o_sample_ready ##[1:2] o_sample_ready)
    else $error("ready after reset");
  mode_error_a: assert property ($fell(i_cs_n) && i_lane_width == 2'h3 |-> ##[2:6] o_mode_error)
    else $error("width not flagged");
  ddr_frame_c: cover property ($fell(i_cs_n) && i_output_protocol_select == 3'h1);
  quad_frame_c: cover property ($fell(i_cs_n) && i_lane_width == 2'h2);
  full_push_c: cover property (i_sample_valid && !o_sample_ready);
endmodule // amsr_readout_assertions

// ---- amsr_host_model.sv ----
`timescale 1ns/100ps
module amsr_host_model (
  output logic                          o_sclk,
  output logic                          o_cs_n,
  input  wire amsr_pkg::amsr_lanes_type i_chan_a,
  input  wire amsr_pkg::amsr_lanes_type i_chan_b
);
  import amsr_pkg::*;
  logic [15:0] cap_a;
  logic [15:0] cap_b;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
  end
  // Lanes lag a pin edge by about four system clocks, so a bit is taken
  // 60 ns after the edge that follows its launch
  // A read of fewer than sixteen bits stops after bits/n steps, rounded up to a whole step; untaken bits stay 0
  task automatic read_frame(input logic pol, input logic pha, input logic ddr, input int n,
                            input int bits);
    int s;
    int k;
    int steps;
    logic launch;
    s = 0;
    steps = (bits + n - 1) / n;
    launch = 1'b0;
    cap_a = '0;
    cap_b = '0;
    o_sclk = pol;
    #107;
    o_cs_n = 1'b0;
    #200;
    for (k = 0; s < steps || o_sclk !== pol; k++) begin
      if (k > 0) o_sclk = ~o_sclk;
      #60;
      for (int j = 0; j < n && launch && s < steps; j++) begin
        cap_a[15 - s * n - j] = i_chan_a.lane_out[j];
        cap_b[15 - s * n - j] = i_chan_b.lane_out[j];
      end
      if (launch && s < steps) s++;
      launch = ddr ? k > 0 : (pha ? k[0] : !k[0]);
      #40;
    end
    o_cs_n = 1'b1;
    #400;
  endtask
endmodule // amsr_host_model

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
  import amsr_pkg::*;
  logic           i_clk = 1'b0;
  logic           i_reset_n = 1'b0;
  logic           i_sclk;
  logic           i_cs_n;
  logic [2:0]     i_output_protocol_select = 3'h0;
  logic           i_clock_polarity_bit = 1'b0;
  logic           i_clock_phase_bit = 1'b0;
  logic [1:0]     i_lane_width = 2'h0;
  logic           i_fixed_pattern_en = 1'b0;
  logic [15:0]    i_fixed_pattern = 16'h0;
  logic           i_sample_valid = 1'b0;
  logic           o_sample_ready;
  amsr_pair_type  i_sample = '0;
  amsr_lanes_type o_chan_a;
  amsr_lanes_type o_chan_b;
  logic           o_busy;
  logic           o_underrun;
  logic           o_mode_error;
  logic [6:0]     modes [9] = '{7'h00, 7'h04, 7'h08, 7'h0c, 7'h01, 7'h0e, 7'h14, 7'h1d, 7'h16};
  int             num_errors = 0;
  int             num_checks = 0;
  always #12.5 i_clk = ~i_clk;
  amsr_readout u_dut (.i_clk, .i_reset_n, .i_sclk, .i_cs_n, .i_output_protocol_select,
    .i_clock_polarity_bit, .i_clock_phase_bit, .i_lane_width, .i_fixed_pattern_en,
    .i_fixed_pattern, .i_sample_valid, .o_sample_ready, .i_sample, .o_chan_a, .o_chan_b,
    .o_busy, .o_underrun, .o_mode_error);
  amsr_host_model u_host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .i_chan_a(o_chan_a),
    .i_chan_b(o_chan_b));
  function automatic logic [15:0] wa(input int i);
    return 16'h8421 + 16'h1357 * i[15:0];
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic push(input int i);
    @(negedge i_clk);
    i_sample = {wa(i), ~wa(i)};
    i_sample_valid = 1'b1;
    @(negedge i_clk);
    i_sample_valid = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic frame(input logic [6:0] m, input int bits, input logic [15:0] ea,
                       input logic [15:0] eb);
    int   lanes;
    logic bad_mode;
    lanes = m[1:0] == 2'h2 ? 4 : m[1:0] == 2'h1 ? 2 : 1;
    // DDR asked with phase 0 is forced to phase 1 and flagged
    bad_mode = m[1:0] == 2'h3 || m[6:4] > 3'h1 || {m[6:4], m[2]} == 4'h2;
    @(negedge i_clk);
    {i_output_protocol_select, i_clock_polarity_bit, i_clock_phase_bit, i_lane_width} = m;
    u_host.read_frame(m[3], m[2], m[6:4] == 3'h1, lanes, bits);
    check("chan a", u_host.cap_a, ea);
    check("chan b", u_host.cap_b, eb);
    check("mode error", o_mode_error, bad_mode);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge i_clk);
    check("reset", {o_busy, o_underrun, o_mode_error, o_chan_a, o_chan_b}, 19'h0);
    i_reset_n = 1'b1;
    repeat (3) @(negedge i_clk);
    // The ninth push meets a full buffer and must be dropped
    for (int i = 0; i < 9; i++) begin
      check("ready", o_sample_ready, i < 8);
      push(i);
    end
    for (int i = 0; i < 9; i++) begin
      frame(modes[i], 16, wa(i < 8 ? i : 7), ~wa(i < 8 ? i : 7));
      check("underrun", o_underrun, i == 8);
    end
    frame(7'h03, 16, wa(7), ~wa(7));
    frame(7'h58, 16, wa(7), ~wa(7));
    frame(7'h11, 16, wa(7), ~wa(7));
    // Fourteen-bit reads: the host stops after the top fourteen bits
    frame(7'h00, 14, wa(7) & 16'hfffc, ~wa(7) & 16'hfffc);
    frame(7'h0d, 14, wa(7) & 16'hfffc, ~wa(7) & 16'hfffc);
    frame(7'h14, 14, wa(7) & 16'hfffc, ~wa(7) & 16'hfffc);
    @(negedge i_clk);
    i_fixed_pattern_en = 1'b1;
    i_fixed_pattern = 16'hc35a;
    frame(7'h06, 16, 16'hc35a, 16'hc35a);
    report_and_stop();
  end
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
endmodule // tb
bind amsr_readout amsr_readout_assertions u_chk (.i_clk, .i_reset_n, .i_sclk, .i_cs_n,
  .i_output_protocol_select, .i_lane_width, .i_sample_valid, .o_sample_ready, .o_chan_a,
  .o_chan_b, .o_busy, .o_mode_error);
